// >>> design/spc_pkg.sv
// Shared constants and types for the serial converter control port.
// Assumes a single 40 MHz system clock; all pins are asynchronous to it.
package spc_pkg;

    localparam int CLOCK_HZ = 40_000_000;

    // Command codes, sent MSB first in the first three serial cycles
    typedef enum logic [2:0] {
        SPC_CMD_SELECT_CHANNEL = 3'h0,
        SPC_CMD_WRITE_CTRL = 3'h4,
        SPC_CMD_READ_CTRL = 3'h5,
        SPC_CMD_WRITE_RESULT = 3'h6,
        SPC_CMD_READ_RESULT = 3'h7
    } spc_cmd_type;

    // Frame geometry in serial cycles
    localparam logic [3:0] FRAME_CYCLES = 4'hC;
    localparam logic [3:0] CMD_CYCLES = 4'h3;
    localparam logic [3:0] LAST_DATA_CYCLE = 4'hB;

    // Bit positions inside the 12-bit captured frame (bit 11 = cycle 1)
    localparam int FRAME_CMD_MSB = 11;
    localparam int FRAME_DATA_MSB = 8;
    localparam int FRAME_OSC_BIT = 8;
    localparam int FRAME_SEL_MSB = 3;

    // Control register fields
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_START_STOP_BIT = 1;
    localparam int CTRL_RUN_BIT = 3;
    localparam int CTRL_LOW_RESULT_LSB = 4;

    // Reset values (no reset value is printed; cleared on chip-off)
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [2:0] SELECT_RESET = 3'h0;

    // Conversion takes 2 x 44.5 oscillator periods
    localparam real CONV_OSC_PERIODS_HALF = 44.5;
    localparam logic [6:0] CONV_OSC_PERIODS = 7'(int'(2.0 * CONV_OSC_PERIODS_HALF));
    // Oscillator periods spent on each of the twelve trial bits
    localparam logic [2:0] SAR_STEP_PERIODS = 3'h7;
    localparam int RESULT_BITS = 12;

    // Synchronised pin bundle
    typedef struct packed {
        logic chip_on;
        logic serial_clock;
        logic serial_in;
        logic osc_clock;
        logic comp_high;
    } spc_pins_type;

    // Conversion engine result
    typedef struct packed {
        logic done;
        logic [RESULT_BITS-1:0] value;
    } spc_conv_type;

endpackage : spc_pkg

// >>> design/spc_sync.sv
// Two-flip-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
module spc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : spc_sync

// >>> design/spc_sar_engine.sv
// Successive-approximation sequencer paced by the conversion oscillator.
// Assumes an external capacitor DAC and comparator; o_trial_code drives
// the DAC and i_comp_high is the synchronised comparator answer.
module spc_sar_engine (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_start,
    input wire logic i_osc_tick,
    input wire logic i_comp_high,
    output logic o_busy,
    output logic [spc_pkg::RESULT_BITS-1:0] o_trial_code,
    output spc_pkg::spc_conv_type o_conv
);
    import spc_pkg::*;

    logic [6:0] period_cnt;
    logic [2:0] step_cnt;
    logic [3:0] bit_idx;
    logic [RESULT_BITS-1:0] trial;

    wire step_end = i_osc_tick && (step_cnt == SAR_STEP_PERIODS - 3'h1);
    wire deciding = step_end && (bit_idx != 4'h0);
    wire conv_end = i_osc_tick && (period_cnt == CONV_OSC_PERIODS - 7'h01);
    wire [RESULT_BITS-1:0] cur_mask = RESULT_BITS'(1) << (bit_idx - 4'h1);
    wire [RESULT_BITS-1:0] kept = i_comp_high ? trial : (trial & ~cur_mask);
    wire [RESULT_BITS-1:0] next_trial = (bit_idx > 4'h1) ? (kept | (cur_mask >> 1)) : kept;

    assign o_trial_code = trial;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            period_cnt <= 7'h00;
            step_cnt <= 3'h0;
            bit_idx <= 4'h0;
            trial <= '0;
            o_conv <= '0;
        end else if (i_clear) begin
            o_busy <= 1'b0;
            period_cnt <= 7'h00;
            step_cnt <= 3'h0;
            bit_idx <= 4'h0;
            trial <= '0;
            o_conv <= '0;
        end else begin
            o_conv.done <= 1'b0;
            if (i_start && !o_busy) begin
                o_busy <= 1'b1;
                period_cnt <= 7'h00;
                step_cnt <= 3'h0;
                bit_idx <= 4'(RESULT_BITS);
                trial <= RESULT_BITS'(1) << (RESULT_BITS - 1);
            end else if (o_busy && i_osc_tick) begin
                period_cnt <= period_cnt + 7'h01;
                step_cnt <= step_end ? 3'h0 : step_cnt + 3'h1;
                if (deciding) begin
                    trial <= next_trial;
                    bit_idx <= bit_idx - 4'h1;
                end
                if (conv_end) begin
                    o_busy <= 1'b0;
                    o_conv.done <= 1'b1;
                    o_conv.value <= trial;
                end
            end
        end
    end
endmodule : spc_sar_engine

// >>> design/spc_serial_adc_control_port.sv
// Serial control port and register file of a 12-bit SAR converter.
// Assumes the host drives a 12-cycle frame on serial clock / serial in,
// samples serial out on the rising serial clock edge, and that the
// conversion oscillator is an RC clock far slower than i_clock.
module spc_serial_adc_control_port (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_chip_on,
    input wire logic i_serial_clock,
    input wire logic i_serial_in,
    input wire logic i_osc_clock,
    input wire logic i_comp_high,
    output logic o_serial_out,
    output logic o_serial_out_en,
    output logic o_osc_enable,
    output logic [2:0] o_input_select,
    output logic [7:0] o_analog_inputs,
    output logic [spc_pkg::RESULT_BITS-1:0] o_trial_code,
    output logic o_conv_done_pulse,
    output logic o_converting
);
    import spc_pkg::*;

    // Pin synchronisation
    spc_pins_type pins_async;
    spc_pins_type pins;
    spc_pins_type pins_prev;

    assign pins_async = '{chip_on: i_chip_on, serial_clock: i_serial_clock,
                          serial_in: i_serial_in, osc_clock: i_osc_clock,
                          comp_high: i_comp_high};

    spc_sync #(
        .WIDTH($bits(spc_pins_type))
    ) u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_async(pins_async),
        .o_sync(pins)
    );

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pins_prev <= '0;
        end else begin
            pins_prev <= pins;
        end
    end

    // Chip-on low acts as a synchronous clear of all functions
    wire chip_active = pins.chip_on;
    wire chip_clear = !chip_active;
    wire sclk_rise = chip_active && pins.serial_clock && !pins_prev.serial_clock;
    wire sclk_fall = chip_active && !pins.serial_clock && pins_prev.serial_clock;

    // Oscillator ticks only while enabled; a stopped RC clock gives none
    logic osc_enable;
    wire osc_tick = osc_enable && pins.osc_clock && !pins_prev.osc_clock;

    // Register file
    logic [7:0] control_reg;
    logic [7:0] result_reg;
    logic [2:0] input_select;

    // Frame reception
    logic [3:0] cycle_cnt;
    logic [FRAME_CYCLES-1:0] frame_shift;
    logic [7:0] out_shift;
    logic out_bit;
    logic reading;

    wire [3:0] cycle_now = cycle_cnt + 4'h1;
    wire [FRAME_CYCLES-1:0] frame_next = {frame_shift[FRAME_CYCLES-2:0], pins.serial_in};
    wire cmd_known = sclk_rise && (cycle_now == CMD_CYCLES);
    wire frame_done = sclk_rise && (cycle_now == FRAME_CYCLES);

    // Command decode, used for the read snapshot and for frame completion
    function automatic logic cmd_is(input logic [2:0] code, input spc_cmd_type cmd);
        cmd_is = (code == cmd);
    endfunction : cmd_is

    wire [2:0] cmd_early = frame_next[2:0];
    wire [2:0] cmd_full = frame_next[FRAME_CMD_MSB -: 3];
    wire [7:0] frame_data = frame_next[FRAME_DATA_MSB -: 8];
    wire early_read_ctrl = cmd_is(cmd_early, SPC_CMD_READ_CTRL);
    wire early_read_result = cmd_is(cmd_early, SPC_CMD_READ_RESULT);
    // Unlisted codes (001, 010, 011) fall through and do nothing
    wire do_select = frame_done && cmd_is(cmd_full, SPC_CMD_SELECT_CHANNEL);
    wire do_write_ctrl = frame_done && cmd_is(cmd_full, SPC_CMD_WRITE_CTRL);
    wire do_write_result = frame_done && cmd_is(cmd_full, SPC_CMD_WRITE_RESULT);

    // Conversion start condition on the freshly written value
    wire start_req = do_write_ctrl && frame_data[CTRL_RUN_BIT]
                     && frame_data[CTRL_START_STOP_BIT]
                     && !frame_data[CTRL_MODE_BIT];

    // Conversion engine
    logic busy;
    spc_conv_type conv;

    spc_sar_engine u_sar (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_clear(chip_clear),
        .i_start(start_req),
        .i_osc_tick(osc_tick),
        .i_comp_high(pins.comp_high),
        .o_busy(busy),
        .o_trial_code(o_trial_code),
        .o_conv(conv)
    );

    // Read data cycles are 4..11; the bit is launched on the falling edge
    // ahead of the host's sampling edge of that cycle
    wire out_launch = sclk_fall && reading
                      && (cycle_cnt >= CMD_CYCLES) && (cycle_cnt < LAST_DATA_CYCLE);

    // Frame counter and input shift register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cycle_cnt <= 4'h0;
            frame_shift <= '0;
        end else if (chip_clear) begin
            cycle_cnt <= 4'h0;
            frame_shift <= '0;
        end else if (sclk_rise) begin
            frame_shift <= frame_next;
            cycle_cnt <= frame_done ? 4'h0 : cycle_now;
        end
    end

    // Output path: snapshot after the command, shift on falling edges
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            reading <= 1'b0;
            out_shift <= 8'h00;
            out_bit <= 1'b0;
        end else if (chip_clear) begin
            reading <= 1'b0;
            out_shift <= 8'h00;
            out_bit <= 1'b0;
        end else if (cmd_known) begin
            reading <= early_read_ctrl || early_read_result;
            out_shift <= early_read_result ? result_reg : control_reg;
        end else if (frame_done) begin
            reading <= 1'b0;
            out_bit <= 1'b0;
        end else if (out_launch) begin
            out_bit <= out_shift[7];
            out_shift <= {out_shift[6:0], 1'b0};
        end
    end

    // Channel select and oscillator enable
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_enable <= 1'b0;
            input_select <= SELECT_RESET;
        end else if (chip_clear) begin
            osc_enable <= 1'b0;
            input_select <= SELECT_RESET;
        end else if (do_select) begin
            osc_enable <= frame_next[FRAME_OSC_BIT];
            input_select <= frame_next[FRAME_SEL_MSB -: 3];
        end
    end

    // Control register: host write, then hardware completion on top.
    // Completion is applied last so a colliding write cannot hide it.
    wire [7:0] ctrl_after_write = do_write_ctrl ? frame_data : control_reg;
    wire [7:0] ctrl_done_clear = ~((8'h01 << CTRL_RUN_BIT) | (8'h01 << CTRL_START_STOP_BIT));
    wire [7:0] ctrl_after_done = {conv.value[3:0], ctrl_after_write[3:0] & ctrl_done_clear[3:0]};
    wire [7:0] next_control = conv.done ? ctrl_after_done : ctrl_after_write;
    wire [7:0] next_result = conv.done ? conv.value[RESULT_BITS-1 -: 8]
                             : (do_write_result ? frame_data : result_reg);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            control_reg <= CTRL_RESET;
            result_reg <= RESULT_RESET;
        end else if (chip_clear) begin
            control_reg <= CTRL_RESET;
            result_reg <= RESULT_RESET;
        end else begin
            control_reg <= next_control;
            result_reg <= next_result;
        end
    end

    // Done pulse: raised with the bit clearing, held one oscillator period
    logic done_pulse;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            done_pulse <= 1'b0;
        end else if (chip_clear) begin
            done_pulse <= 1'b0;
        end else if (conv.done) begin
            done_pulse <= 1'b1;
        end else if (osc_tick || !osc_enable) begin
            // A stopped oscillator would otherwise leave the pulse stuck high
            done_pulse <= 1'b0;
        end
    end

    // Analog routing: select value n picks input n
    genvar ch;
    generate
        for (ch = 0; ch < 8; ch++) begin : g_route
            assign o_analog_inputs[ch] = chip_active && (input_select == 3'(ch));
        end
    endgenerate

    assign o_serial_out = out_bit;
    assign o_serial_out_en = chip_active;
    assign o_osc_enable = osc_enable;
    assign o_input_select = input_select;
    assign o_conv_done_pulse = done_pulse;
    assign o_converting = busy;

endmodule : spc_serial_adc_control_port

// >>> verification/spc_chk.sv
// Pin-level checker for the serial converter control port.
// Assumes one i_clock domain and an oscillator far slower than i_clock.
module spc_chk (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_chip_on,
    input wire logic i_osc_clock,
    input wire logic o_serial_out,
    input wire logic o_serial_out_en,
    input wire logic o_osc_enable,
    input wire logic [2:0] o_input_select,
    input wire logic [7:0] o_analog_inputs,
    input wire logic [spc_pkg::RESULT_BITS-1:0] o_trial_code,
    input wire logic o_conv_done_pulse,
    input wire logic o_converting
);
    timeunit 1ns;
    timeprecision 1ps;
    import spc_pkg::*;
    logic [2:0] osc_q;
    logic [7:0] osc_cnt;
    // Own synchroniser, same depth as the design's, so oscillator edges line up to the cycle
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            osc_q <= 3'h0;
            osc_cnt <= 8'h00;
        end else begin
            osc_q <= {osc_q[1:0], i_osc_clock};
            if (!o_converting) osc_cnt <= 8'h00;
            else if (osc_q[1] && !osc_q[2]) osc_cnt <= osc_cnt + 8'h01;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    AST_OFF_CLEAR: assert property (!i_chip_on [*5] |-> !o_serial_out_en && !o_serial_out
        && !o_converting && !o_osc_enable && !o_conv_done_pulse && o_trial_code == 12'h000)
        else $error("state not cleared while chip is off");
    AST_ON_DRIVE: assert property (i_chip_on [*4] |-> o_serial_out_en)
        else $error("serial out not driven while chip is on");
    AST_ROUTE: assert property (o_serial_out_en |-> o_analog_inputs == 8'h01 << o_input_select)
        else $error("analog route does not match select");
    AST_START_OSC: assert property ($rose(o_converting) |-> o_osc_enable)
        else $error("conversion started without oscillator");
    AST_BUSY_HOLD: assert property ($rose(o_converting) |-> (o_converting && !o_conv_done_pulse) [*8])
        else $error("conversion ended at once");
    AST_DONE_AT_END: assert property ($fell(o_converting) && o_serial_out_en |-> ##[0:2] o_conv_done_pulse)
        else $error("no done pulse at end of conversion");
    AST_DONE_LEN: assert property ($rose(o_conv_done_pulse) |-> o_conv_done_pulse [*8] ##[1:40] !o_conv_done_pulse)
        else $error("done pulse length wrong");
    AST_CONV_LEN: assert property ($fell(o_converting) && o_serial_out_en |-> osc_cnt inside {[88:89]})
        else $error("conversion length not 89 periods");
endmodule : spc_chk

bind spc_serial_adc_control_port spc_chk u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_chip_on(i_chip_on), .i_osc_clock(i_osc_clock), .o_serial_out(o_serial_out),
    .o_serial_out_en(o_serial_out_en), .o_osc_enable(o_osc_enable),
    .o_input_select(o_input_select), .o_analog_inputs(o_analog_inputs),
    .o_trial_code(o_trial_code), .o_conv_done_pulse(o_conv_done_pulse),
    .o_converting(o_converting));

// >>> verification/spc_host.sv
// Host model: drives 12-cycle serial frames and reads back data bits.
// Assumes the caller runs in i_clock time; serial clock idles low.
module spc_host (
    input wire logic i_clock,
    input wire logic i_serial_out,
    output logic o_serial_clock,
    output logic o_serial_in,
    output logic o_rd_done,
    output logic [7:0] o_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_serial_clock = 1'b0;
        o_serial_in = 1'b0;
        o_rd_done = 1'b0;
        o_rd_data = 8'h00;
    end
    // 4 cycles low, 4 high: 200 ns; data changes with the falling edge
    task automatic run_frame(input logic [11:0] bits);
        logic [7:0] rd;
        rd = 8'h00;
        @(posedge i_clock);
        for (int k = 11; k >= 0; k--) begin
            o_serial_clock <= 1'b0;
            o_serial_in <= bits[k];
            repeat (4) @(posedge i_clock);
            o_serial_clock <= 1'b1;
            repeat (2) @(posedge i_clock);
            if (k >= 1 && k <= 8) rd[k-1] = i_serial_out;
            repeat (2) @(posedge i_clock);
        end
        o_serial_clock <= 1'b0;
        // Released line shows the inverse, not a stale level
        o_serial_in <= ~bits[0];
        if (bits[11] && bits[9]) begin
            o_rd_done <= 1'b1;
            o_rd_data <= rd;
            @(posedge i_clock);
            o_rd_done <= 1'b0;
        end
    endtask : run_frame
endmodule : spc_host

// >>> verification/tb_top.sv
// Self-checking bench for the serial converter control port.
// Assumes the host model for framing and a behavioural comparator.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import spc_pkg::*;
    logic i_clock, i_rst_n, i_chip_on, i_osc_clock, i_comp_high;
    wire logic sclk, sin, sout, sout_en, osc_en, busy, done, rd_done;
    wire logic [2:0] sel;
    wire logic [7:0] route, rd_data;
    wire logic [RESULT_BITS-1:0] trial;
    int fails, n_tests, seed, osc_div;
    logic [7:0] exp_q[$];
    logic [11:0] vin[8];
    logic [7:0] d;
    logic [2:0] ch;
    logic [3:0] opamp_bits;

    spc_serial_adc_control_port uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_chip_on(i_chip_on), .i_serial_clock(sclk), .i_serial_in(sin),
        .i_osc_clock(i_osc_clock), .i_comp_high(i_comp_high), .o_serial_out(sout),
        .o_serial_out_en(sout_en), .o_osc_enable(osc_en), .o_input_select(sel),
        .o_analog_inputs(route), .o_trial_code(trial), .o_conv_done_pulse(done),
        .o_converting(busy));
    spc_host uhost (.i_clock(i_clock), .i_serial_out(sout), .o_serial_clock(sclk),
        .o_serial_in(sin), .o_rd_done(rd_done), .o_rd_data(rd_data));

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    // 2 MHz oscillator and an ideal comparator on the routed input
    always @(posedge i_clock) begin
        osc_div <= (osc_div == 9) ? 0 : osc_div + 1;
        if (osc_div == 9) i_osc_clock <= ~i_osc_clock;
        i_comp_high <= vin[sel] >= trial;
    end

    task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // Ends on a falling edge so callers compare settled outputs
    task automatic frame(input logic [2:0] cmd, input logic [7:0] data);
        uhost.run_frame({cmd, data, 1'b0});
        @(negedge i_clock);
    endtask : frame

    task automatic wait_done(input int lim);
        int i;
        for (i = 0; i < lim && done !== 1'b1; i++) @(posedge i_clock);
        if (i == lim) begin
            fails++;
            $display("unexpected at %0t: no end of conversion", $time);
            final_report();
        end
    endtask : wait_done

    // Takes the oldest note whenever the host completes a read
    always @(posedge i_clock) begin
        if (rd_done === 1'b1) begin
            if (exp_q.size() == 0) check(12'h000, 12'hFFF, "read without note");
            else check({4'h0, rd_data}, {4'h0, exp_q.pop_front()}, "read data");
        end
    end

    initial begin
        seed = 32'h5776;
        fails = 0;
        n_tests = 0;
        osc_div = 0;
        i_rst_n = 1'b0;
        i_chip_on = 1'b0;
        i_osc_clock = 1'b0;
        i_comp_high = 1'b0;
        for (int i = 0; i < 8; i++) vin[i] = 12'($random(seed));
        // Opamp bits are random once, then kept in every select frame
        opamp_bits = 4'($random(seed));
        repeat (6) @(posedge i_clock);
        i_rst_n <= 1'b1;
        repeat (6) @(negedge i_clock);
        check(12'(sout_en), 12'h000, "driven while off");
        @(posedge i_clock);
        i_chip_on <= 1'b1;
        repeat (6) @(negedge i_clock);
        check(12'(sout_en), 12'h001, "not driven while on");
        $display("test chip enable done");

        // Mode bit set with run and start: stored but no conversion
        d = 8'($random(seed)) | 8'h0B;
        frame(SPC_CMD_WRITE_CTRL, d);
        check(12'(busy), 12'h000, "mode bit started conversion");
        for (int c = 1; c < 4; c++) frame(3'(c), ~d);
        exp_q.push_back(d);
        frame(SPC_CMD_READ_CTRL, 8'($random(seed)));
        d = 8'($random(seed));
        frame(SPC_CMD_WRITE_RESULT, d);
        exp_q.push_back(d);
        frame(SPC_CMD_READ_RESULT, 8'($random(seed)));
        $display("test register access done");

        for (int n = 0; n < 8; n++) begin
            frame(SPC_CMD_SELECT_CHANNEL, {n[0], opamp_bits, 3'(n)});
            check(12'(sel), 12'(n), "select");
            check(12'(route), 12'(8'h01 << n), "route");
            check(12'(osc_en), 12'(n[0]), "oscillator enable");
        end
        $display("test channel select done");

        for (int t = 0; t < 3; t++) begin
            ch = 3'($random(seed));
            frame(SPC_CMD_SELECT_CHANNEL, {1'b1, opamp_bits, ch});
            frame(SPC_CMD_WRITE_CTRL, {4'($random(seed)), 4'hA});
            check(12'(busy), 12'h001, "conversion not started");
            if (t == 2) begin
                // Chip-off in mid conversion must clear everything
                repeat (100) @(posedge i_clock);
                i_chip_on <= 1'b0;
                repeat (8) @(negedge i_clock);
                check(12'(busy), 12'h000, "busy while off");
                @(posedge i_clock);
                i_chip_on <= 1'b1;
                repeat (6) @(posedge i_clock);
                exp_q.push_back(8'h00);
                frame(SPC_CMD_READ_CTRL, 8'h00);
                check(12'(sel), 12'h000, "select kept over chip-off");
            end else begin
                wait_done(3000);
                exp_q.push_back({vin[ch][3:0], 4'h0});
                frame(SPC_CMD_READ_CTRL, 8'h00);
                exp_q.push_back(vin[ch][11:4]);
                frame(SPC_CMD_READ_RESULT, 8'h00);
            end
        end
        $display("test conversion done");
        repeat (20) @(posedge i_clock);
        check(12'(exp_q.size()), 12'h000, "reads missing");
        final_report();
    end
endmodule : tb_top
